// ### common/usb_ep_xfer_pkg.sv
// constants and carrier types for the endpoint transfer-size register bank
package usb_ep_xfer_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses, one aligned word per register)
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int WORD_BYTES = 4;
  localparam logic [ADDR_W-1:0] IN_TSIZE_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] TX_FREE_BASE = 12'h020;
  localparam logic [ADDR_W-1:0] OUT_TSIZE_BASE = 12'h040;
  localparam logic [ADDR_W-1:0] INT_STATUS_ADDR = 12'h060;
  localparam logic [ADDR_W-1:0] INT_ENABLE_ADDR = 12'h064;
  localparam logic [ADDR_W-1:0] INT_CLEAR_ADDR = 12'h068;

  // ----------------------------------------------------------------------
  // field layout of the transfer-size and free-space registers
  // ----------------------------------------------------------------------
  localparam int MULT_LSB = 29;
  localparam int MULT_W = 2;
  localparam int PKT_LSB = 19;
  localparam int PKT_W = 10;
  localparam int BYTES_LSB = 0;
  localparam int BYTES_W = 19;
  localparam int FREE_W = 16;
  localparam logic [FREE_W-1:0] FREE_RESET = 16'h0200;

  // ----------------------------------------------------------------------
  // data pid codes and per-event byte count width
  // ----------------------------------------------------------------------
  localparam logic [1:0] PID_DATA0 = 2'h0;
  localparam logic [1:0] PID_DATA2 = 2'h1;
  localparam logic [1:0] PID_DATA1 = 2'h2;
  localparam logic [1:0] PID_MDATA = 2'h3;
  localparam int EVT_BYTES_W = 11;
  localparam int EP_NUM_W = 3;

  // one packet movement reported by the controller core
  typedef struct packed {
    logic valid;
    logic [EP_NUM_W-1:0] ep;
    logic [EVT_BYTES_W-1:0] bytes;
    logic [1:0] pid;
    logic setup;
  } xfer_evt_t;

endpackage

// ### hw/usb_dev_ep_xfer_size_regs.sv
// transfer-size, tx fifo free-space and zero-count interrupt registers
`timescale 1ns/1ps
module usb_dev_ep_xfer_size_regs
  import usb_ep_xfer_pkg::*;
#(
  parameter int NUM_EP = 7
)
(
  // clock, reset and clock enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // endpoint enable bits from the endpoint control registers, and the frame pulse
  input wire logic [NUM_EP:1] inEpEnable,
  input wire logic [NUM_EP:1] outEpEnable,
  input wire logic frameStart,
  // packet movements reported by the controller core
  input wire xfer_evt_t inFifoFill,
  input wire xfer_evt_t inFifoDrain,
  input wire xfer_evt_t outFifoFill,
  input wire xfer_evt_t outFifoDrain,
  // status towards the controller core and the cpu
  output logic [NUM_EP:1][1:0] isoTxPid,
  output logic [NUM_EP:1] setupAccept,
  output logic irq
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // true when an event addresses endpoint n
  function automatic logic epHit(input xfer_evt_t e, input int n);
    epHit = e.valid && (e.ep == EP_NUM_W'(n));
  endfunction

  // byte address of the register of endpoint n in a bank
  function automatic logic [ADDR_W-1:0] regAddr(
    input logic [ADDR_W-1:0] base, input int n);
    regAddr = base + ADDR_W'(n * WORD_BYTES);
  endfunction

  // byte count minus one packet, never below zero
  function automatic logic [BYTES_W-1:0] subBytes(
    input logic [BYTES_W-1:0] a, input logic [EVT_BYTES_W-1:0] b);
    logic [BYTES_W-1:0] bw;
    bw = {{(BYTES_W-EVT_BYTES_W){1'b0}}, b};
    subBytes = (bw >= a) ? '0 : a - bw;
  endfunction

  // packet size in bytes rounded up to whole fifo words
  // a short packet still takes a whole word in the fifo
  function automatic logic [FREE_W-1:0] wordsOf(
    input logic [EVT_BYTES_W-1:0] b);
    logic [EVT_BYTES_W:0] s;
    s = {1'b0, b} + 12'h003;
    wordsOf = {{(FREE_W-EVT_BYTES_W+1){1'b0}}, s[EVT_BYTES_W:2]};
  endfunction

  // pid of the next iso IN packet from packets still due this frame
  // one packet due, or none left, always goes out as DATA0
  function automatic logic [1:0] pidFor(input logic [1:0] left);
    case (left)
      2'h3: pidFor = PID_DATA2;
      2'h2: pidFor = PID_DATA1;
      default: pidFor = PID_DATA0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  // per-endpoint state, indexed by endpoint number from 1
  logic [MULT_W-1:0] mult_reg [1:NUM_EP];
  logic [MULT_W-1:0] mult_next [1:NUM_EP];
  logic [PKT_W-1:0] inPkts_reg [1:NUM_EP];
  logic [PKT_W-1:0] inPkts_next [1:NUM_EP];
  logic [BYTES_W-1:0] inBytes_reg [1:NUM_EP];
  logic [BYTES_W-1:0] inBytes_next [1:NUM_EP];
  logic [FREE_W-1:0] txFree_reg [1:NUM_EP];
  logic [FREE_W-1:0] txFree_next [1:NUM_EP];
  logic [1:0] frameLeft_reg [1:NUM_EP];
  logic [1:0] frameLeft_next [1:NUM_EP];
  logic [PKT_W-1:0] outPkts_reg [1:NUM_EP];
  logic [PKT_W-1:0] outPkts_next [1:NUM_EP];
  logic [BYTES_W-1:0] outBytes_reg [1:NUM_EP];
  logic [BYTES_W-1:0] outBytes_next [1:NUM_EP];
  logic [1:0] lastRxPid_reg [1:NUM_EP];
  logic [1:0] lastRxPid_next [1:NUM_EP];
  logic [1:0] setupLeft_reg [1:NUM_EP];
  logic [1:0] setupLeft_next [1:NUM_EP];
  logic [NUM_EP:1][1:0] isoTxPid_reg;
  logic [NUM_EP:1][1:0] isoTxPid_next;
  logic [NUM_EP:1] setupAccept_reg;
  logic [NUM_EP:1] setupAccept_next;
  logic [2*NUM_EP-1:0] zeroSet;

  logic wrPend_reg;
  logic wrPend_next;
  logic [ADDR_W-1:0] wrAddr_reg;
  logic [ADDR_W-1:0] wrAddr_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic [2*NUM_EP-1:0] intStatus_reg;
  logic [2*NUM_EP-1:0] intStatus_next;
  logic [2*NUM_EP-1:0] intEnable_reg;
  logic [2*NUM_EP-1:0] intEnable_next;
  logic irq_reg;
  logic irq_next;
  logic hreadyout_reg;
  logic hresp_reg;

  // ----------------------------------------------------------------------
  // endpoint counters
  // ----------------------------------------------------------------------

  // software loads only disabled endpoints; hardware counts only enabled, except fifo free space and the frame-start reload on every endpoint
  always_comb
  begin
    zeroSet = '0;
    for (int n = 1; n <= NUM_EP; n++)
    begin
      mult_next[n] = mult_reg[n];
      inPkts_next[n] = inPkts_reg[n];
      inBytes_next[n] = inBytes_reg[n];
      txFree_next[n] = txFree_reg[n];
      frameLeft_next[n] = frameLeft_reg[n];
      outPkts_next[n] = outPkts_reg[n];
      outBytes_next[n] = outBytes_reg[n];
      lastRxPid_next[n] = lastRxPid_reg[n];
      setupLeft_next[n] = setupLeft_reg[n];
      // writes to an enabled endpoint are dropped, counts stay coherent
      if (wrPend_reg && wrAddr_reg == regAddr(IN_TSIZE_BASE, n)
          && !inEpEnable[n])
      begin
        mult_next[n] = hwdata[MULT_LSB +: MULT_W];
        inPkts_next[n] = hwdata[PKT_LSB +: PKT_W];
        inBytes_next[n] = hwdata[BYTES_LSB +: BYTES_W];
      end
      if (wrPend_reg && wrAddr_reg == regAddr(OUT_TSIZE_BASE, n)
          && !outEpEnable[n])
      begin
        setupLeft_next[n] = hwdata[MULT_LSB +: MULT_W];
        outPkts_next[n] = hwdata[PKT_LSB +: PKT_W];
        outBytes_next[n] = hwdata[BYTES_LSB +: BYTES_W];
      end
      // fifo occupancy tracks every push and pop, enabled or not
      // no clamp: a pop without its push shows as a wrap, not hidden
      if (epHit(inFifoFill, n))
        txFree_next[n] = txFree_next[n] - wordsOf(inFifoFill.bytes);
      if (epHit(inFifoDrain, n))
        txFree_next[n] = txFree_next[n] + wordsOf(inFifoDrain.bytes);
      // IN counts: bytes on fill from memory, packets on drain to usb
      if (inEpEnable[n] && epHit(inFifoFill, n))
      begin
        inBytes_next[n] = subBytes(inBytes_reg[n], inFifoFill.bytes);
        if (inBytes_reg[n] != '0 && inBytes_next[n] == '0)
          zeroSet[n-1] = 1'b1;
      end
      // a frame start wins over a drain in the same cycle
      if (frameStart)
        frameLeft_next[n] = mult_reg[n];
      else if (inEpEnable[n] && epHit(inFifoDrain, n)
               && frameLeft_reg[n] != 2'h0)
        frameLeft_next[n] = frameLeft_reg[n] - 2'h1;
      if (inEpEnable[n] && epHit(inFifoDrain, n)
          && inPkts_reg[n] != '0)
        inPkts_next[n] = inPkts_reg[n] - 10'h001;
      // OUT counts: packets on receive fifo write, bytes on store
      // the pid is kept for every packet; only iso endpoints use it
      if (outEpEnable[n] && epHit(outFifoFill, n))
      begin
        if (outPkts_reg[n] != '0)
          outPkts_next[n] = outPkts_reg[n] - 10'h001;
        lastRxPid_next[n] = outFifoFill.pid;
        if (outFifoFill.setup && setupLeft_reg[n] != 2'h0)
          setupLeft_next[n] = setupLeft_reg[n] - 2'h1;
      end
      if (outEpEnable[n] && epHit(outFifoDrain, n))
      begin
        outBytes_next[n] = subBytes(outBytes_reg[n], outFifoDrain.bytes);
        if (outBytes_reg[n] != '0 && outBytes_next[n] == '0)
          zeroSet[NUM_EP+n-1] = 1'b1;
      end
      // taken from next values so the status never lags the counts
      isoTxPid_next[n] = pidFor(frameLeft_next[n]);
      setupAccept_next[n] = (setupLeft_next[n] != 2'h0);
    end
  end

  // endpoint registers; everything holds while ce is low
  // a low ce leaves hreadyout high, so a transfer started then is lost
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int n = 1; n <= NUM_EP; n++)
      begin
        mult_reg[n] <= '0;
        inPkts_reg[n] <= '0;
        inBytes_reg[n] <= '0;
        txFree_reg[n] <= FREE_RESET;
        frameLeft_reg[n] <= '0;
        outPkts_reg[n] <= '0;
        outBytes_reg[n] <= '0;
        lastRxPid_reg[n] <= PID_DATA0;
        setupLeft_reg[n] <= '0;
      end
      isoTxPid_reg <= '0;
      setupAccept_reg <= '0;
    end
    else if (ce)
    begin
      mult_reg <= mult_next;
      inPkts_reg <= inPkts_next;
      inBytes_reg <= inBytes_next;
      txFree_reg <= txFree_next;
      frameLeft_reg <= frameLeft_next;
      outPkts_reg <= outPkts_next;
      outBytes_reg <= outBytes_next;
      lastRxPid_reg <= lastRxPid_next;
      setupLeft_reg <= setupLeft_next;
      isoTxPid_reg <= isoTxPid_next;
      setupAccept_reg <= setupAccept_next;
    end
  end

  // ----------------------------------------------------------------------
  // bus slave and interrupt
  // ----------------------------------------------------------------------

  // zero wait states: read data is fetched at the address phase edge, so a
  // read straight after a write to the same register returns the old value
  always_comb
  begin
    wrPend_next = 1'b0;
    wrAddr_next = wrAddr_reg;
    hrdata_next = hrdata_reg;
    intEnable_next = intEnable_reg;
    intStatus_next = intStatus_reg;
    if (hsel && htrans[1] && hready)
    begin
      if (hwrite)
      begin
        wrPend_next = 1'b1;
        wrAddr_next = haddr[ADDR_W-1:0];
      end
      else
      begin
        hrdata_next = '0; // unmapped and reserved read as zero
        for (int n = 1; n <= NUM_EP; n++)
        begin
          if (haddr[ADDR_W-1:0] == regAddr(IN_TSIZE_BASE, n))
            hrdata_next = {1'b0, mult_reg[n], inPkts_reg[n],
                           inBytes_reg[n]};
          if (haddr[ADDR_W-1:0] == regAddr(TX_FREE_BASE, n))
            hrdata_next = {16'h0000, txFree_reg[n]};
          if (haddr[ADDR_W-1:0] == regAddr(OUT_TSIZE_BASE, n))
            hrdata_next = {1'b0, lastRxPid_reg[n], outPkts_reg[n],
                           outBytes_reg[n]};
        end
        if (haddr[ADDR_W-1:0] == INT_STATUS_ADDR)
          hrdata_next = {{(32-2*NUM_EP){1'b0}}, intStatus_reg};
        if (haddr[ADDR_W-1:0] == INT_ENABLE_ADDR)
          hrdata_next = {{(32-2*NUM_EP){1'b0}}, intEnable_reg};
      end
    end
    // free-space registers have no write decode at all
    if (wrPend_reg && wrAddr_reg == INT_ENABLE_ADDR)
      intEnable_next = hwdata[2*NUM_EP-1:0];
    if (wrPend_reg && wrAddr_reg == INT_CLEAR_ADDR)
      intStatus_next = intStatus_reg & ~hwdata[2*NUM_EP-1:0];
    // a clear landing with a zero event keeps the bit, no event is lost
    intStatus_next = intStatus_next | zeroSet; // set beats clear
    irq_next = |(intStatus_next & intEnable_next);
  end

  // bus and interrupt registers; slave never stalls and always says okay
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= '0;
      hrdata_reg <= '0;
      intStatus_reg <= '0;
      intEnable_reg <= '0;
      irq_reg <= 1'b0;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end
    else if (ce)
    begin
      wrPend_reg <= wrPend_next;
      wrAddr_reg <= wrAddr_next;
      hrdata_reg <= hrdata_next;
      intStatus_reg <= intStatus_next;
      intEnable_reg <= intEnable_next;
      irq_reg <= irq_next;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end
  end

  // outputs straight from flops
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign hrdata = hrdata_reg;
  assign isoTxPid = isoTxPid_reg;
  assign setupAccept = setupAccept_reg;
  assign irq = irq_reg;

endmodule

// ### testbench/usb_core_model.sv
// controller-core model issuing packet movements and frame pulses
`timescale 1ns/1ps
module usb_core_model
  import usb_ep_xfer_pkg::*;
(
  // clock
  input wire logic mclk,
  // packet movements and frame pulse
  output xfer_evt_t inFifoFill,
  output xfer_evt_t inFifoDrain,
  output xfer_evt_t outFifoFill,
  output xfer_evt_t outFifoDrain,
  output logic frameStart
);
  // ----------------------------------------------------------------
  // event driver
  // ----------------------------------------------------------------
  // all channels idle at time zero
  initial
  begin
    {inFifoFill, inFifoDrain, outFifoFill, outFifoDrain, frameStart} = '0;
  end

  // one-cycle pulse after lag idle cycles; idle fields show the inverse
  // so a stale packet can never be mistaken for a fresh one
  task automatic send(input int kind, input logic [2:0] ep,
    input logic [10:0] nb, input logic [1:0] pid, input logic stp,
    input int lag);
    xfer_evt_t e;
    repeat (lag) @(posedge mclk);
    e = '{1'b1, ep, nb, pid, stp}; // exact bytes of one packet
    case (kind)
      0: inFifoFill <= e;
      1: inFifoDrain <= e;
      2: outFifoFill <= e;
      default: outFifoDrain <= e;
    endcase
    @(posedge mclk);
    e = ~e;
    e.valid = 1'b0;
    {inFifoFill, inFifoDrain, outFifoFill, outFifoDrain} <= {4{e}};
    @(posedge mclk);
  endtask

  // single frame-start pulse
  task automatic frame();
    frameStart <= 1'b1;
    @(posedge mclk);
    frameStart <= 1'b0;
    @(posedge mclk);
  endtask
endmodule

// ### testbench/usb_dev_ep_xfer_size_regs_sva.sv
// concurrent checks on the transfer-size register bank ports
`timescale 1ns/1ps
module usb_dev_ep_xfer_size_regs_chk
  import usb_ep_xfer_pkg::*;
#(
  parameter int NUM_EP = 7
)
(
  // clock, reset and bus
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // core events
  input wire logic frameStart,
  input wire xfer_evt_t inFifoFill,
  input wire xfer_evt_t inFifoDrain,
  input wire xfer_evt_t outFifoDrain,
  input wire xfer_evt_t outFifoFill,
  // status outputs
  input wire logic [NUM_EP:1][1:0] isoTxPid,
  input wire logic [NUM_EP:1] setupAccept,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // helpers and assertions
  // ----------------------------------------------------------------
  logic wrTaken;
  logic rdTaken;
  logic zeroEvt;
  logic anyMdata;
  assign wrTaken = ce && hsel && htrans[1] && hready && hwrite;
  assign rdTaken = ce && hsel && htrans[1] && hready && !hwrite;
  assign zeroEvt = inFifoFill.valid || outFifoDrain.valid || wrTaken;
  // mdata is never a transmit pid on any endpoint
  always_comb
  begin
    anyMdata = 1'b0;
    for (int k = 1; k <= NUM_EP; k++)
      anyMdata = anyMdata | (isoTxPid[k] == PID_MDATA);
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  chk_resp_okay: assert property (
    hresp == 1'b0) else $error("error response seen");
  chk_rdata_hold: assert property (
    !rdTaken |=> $stable(hrdata)) else $error("read data moved");
  chk_pid_legal: assert property (
    !anyMdata) else $error("mdata chosen as iso pid");
  chk_pid_cause: assert property (
    !$stable(isoTxPid) |-> $past(frameStart || inFifoDrain.valid))
    else $error("iso pid moved without frame or packet");
  chk_irq_rise: assert property (
    $rose(irq) |-> $past(zeroEvt) || $past(zeroEvt, 2)
      || $past(zeroEvt, 3) || $past(zeroEvt, 4))
    else $error("irq rose without a cause");
  chk_irq_fall: assert property (
    $fell(irq) |-> $past(wrTaken, 2) || $past(wrTaken, 3)
      || $past(wrTaken, 4)) else $error("irq fell without a write");
  chk_setup_drop: assert property (
    |($past(setupAccept) & ~setupAccept) |-> $past(wrTaken, 2)
      || $past(wrTaken, 3) || $past(outFifoFill.valid && outFifoFill.setup))
    else $error("setup allowance dropped without a setup packet");
  chk_setup_rise: assert property (
    |(setupAccept & ~$past(setupAccept)) |-> $past(wrTaken, 2)
      || $past(wrTaken, 3)) else $error("setup allowance rose alone");
endmodule

bind usb_dev_ep_xfer_size_regs usb_dev_ep_xfer_size_regs_chk #(
  .NUM_EP(NUM_EP)
) i_usb_dev_ep_xfer_size_regs_chk (
  .mclk, .reset_n, .ce, .hsel, .htrans, .hwrite, .hready, .hresp, .hrdata,
  .frameStart, .inFifoFill, .inFifoDrain, .outFifoDrain, .outFifoFill,
  .isoTxPid, .setupAccept, .irq
);

// ### testbench/usb_dev_ep_xfer_size_regs_tb.sv
// self-checking bench for the transfer-size register bank
`timescale 1ns/1ps
module usb_dev_ep_xfer_size_regs_tb
  import usb_ep_xfer_pkg::*;
;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:1] inEpEnable = 7'h00;
  logic [7:1] outEpEnable = 7'h00;
  logic hreadyout, hresp, frameStart, irq;
  logic [31:0] hrdata;
  logic [7:1][1:0] isoTxPid;
  logic [7:1] setupAccept;
  xfer_evt_t inFifoFill, inFifoDrain, outFifoFill, outFifoDrain;
  int miscompares = 0;
  int cmp_count = 0;

  // ----------------------------------------------------------------
  // clock, design and core model
  // ----------------------------------------------------------------
  always #2 mclk = ~mclk;
  usb_dev_ep_xfer_size_regs #(.NUM_EP(7)) i_usb_dev_ep_xfer_size_regs (
    .mclk, .reset_n, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .inEpEnable, .outEpEnable, .frameStart, .inFifoFill,
    .inFifoDrain, .outFifoFill, .outFifoDrain, .isoTxPid, .setupAccept,
    .irq);
  usb_core_model i_usb_core_model (.mclk, .inFifoFill, .inFifoDrain,
    .outFifoFill, .outFifoDrain, .frameStart);

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] x,
    input string msg);
    cmp_count++;
    if (seen !== x)
    begin
      miscompares++;
      $display("MISMATCH t=%0t %s: %h not %h", $time, msg, seen, x);
    end
  endtask

  // hready is waited for under a bound, never assumed
  task automatic wait_rdy();
    for (int n = 0; n < 50; n++)
    begin
      @(posedge mclk);
      if (hreadyout === 1'b1)
        return;
    end
    chk(32'h0, 32'h1, "bus stall");
  endtask

  // one single transfer; a read compares its data with d
  task automatic acc(input logic w, input logic [11:0] a,
    input logic [31:0] d, input string msg);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    if (!w)
      chk(hrdata, d, msg);
    @(posedge mclk);
  endtask

  task automatic t_reset_ro();
    for (int n = 1; n <= 7; n++)
    begin
      acc(1'b0, TX_FREE_BASE + 12'(4 * n), 32'h0000_0200, "free");
      acc(1'b0, IN_TSIZE_BASE + 12'(4 * n), 32'h0, "in size");
    end
    chk({24'h0, irq, setupAccept}, 32'h0, "pins after reset");
    acc(1'b1, TX_FREE_BASE + 12'h004, 32'h0000_0005, "");
    acc(1'b0, TX_FREE_BASE + 12'h004, 32'h0000_0200, "free ro");
    acc(1'b1, 12'h000, 32'hFFFF_FFFF, "");
    acc(1'b0, 12'h000, 32'h0, "unmapped");
    acc(1'b1, INT_STATUS_ADDR, 32'h0000_3FFF, "");
    acc(1'b0, INT_STATUS_ADDR, 32'h0, "status ro");
  endtask

  task automatic t_in_flow();
    acc(1'b1, IN_TSIZE_BASE + 12'h008, 32'h2010_0064, "");
    acc(1'b1, INT_ENABLE_ADDR, 32'h0000_3FFF, "");
    inEpEnable[2] <= 1'b1;
    i_usb_core_model.send(0, 3'h2, 11'h040, 2'h0, 1'b0, 0);
    acc(1'b0, IN_TSIZE_BASE + 12'h008, 32'h2010_0024, "fill");
    acc(1'b0, TX_FREE_BASE + 12'h008, 32'h0000_01F0, "free");
    acc(1'b1, IN_TSIZE_BASE + 12'h008, 32'h0, "");
    acc(1'b0, IN_TSIZE_BASE + 12'h008, 32'h2010_0024, "owned");
    i_usb_core_model.send(1, 3'h2, 11'h040, 2'h0, 1'b0, 3);
    acc(1'b0, IN_TSIZE_BASE + 12'h008, 32'h2008_0024, "drain");
    acc(1'b0, TX_FREE_BASE + 12'h008, 32'h0000_0200, "freed");
    i_usb_core_model.send(0, 3'h2, 11'h024, 2'h0, 1'b0, 0);
    acc(1'b0, IN_TSIZE_BASE + 12'h008, 32'h2008_0000, "zero");
    acc(1'b0, INT_STATUS_ADDR, 32'h0000_0002, "in status");
    chk({31'h0, irq}, 32'h1, "irq raised");
    acc(1'b1, INT_ENABLE_ADDR, 32'h0, "");
    @(posedge mclk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    acc(1'b1, INT_CLEAR_ADDR, 32'h0000_0002, "");
    acc(1'b1, INT_ENABLE_ADDR, 32'h0000_3FFF, "");
    acc(1'b0, INT_STATUS_ADDR, 32'h0, "cleared");
    inEpEnable[2] <= 1'b0;
  endtask

  // byte count equals one packet, so one drain empties it
  task automatic t_out_flow();
    acc(1'b1, OUT_TSIZE_BASE + 12'h00C, 32'h4018_000A, "");
    @(posedge mclk);
    chk({25'h0, setupAccept}, 32'h0000_0004, "allowance");
    outEpEnable[3] <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      i_usb_core_model.send(2, 3'h3, 11'h008, 2'(i), 1'(i < 2), i);
      acc(1'b0, OUT_TSIZE_BASE + 12'h00C, {1'b0, 2'(i),
        10'(i < 3 ? 2 - i : 0), 19'h0000A}, "out fill");
      chk({31'h0, setupAccept[3]}, {31'h0, 1'(i == 0)}, "setup");
    end
    i_usb_core_model.send(3, 3'h3, 11'h00A, 2'h0, 1'b0, 0);
    acc(1'b0, OUT_TSIZE_BASE + 12'h00C, 32'h6000_0000, "stored");
    acc(1'b0, INT_STATUS_ADDR, 32'h0000_0200, "out status");
    chk({31'h0, irq}, 32'h1, "out irq");
    outEpEnable[3] <= 1'b0;
  endtask

  // packets left 3, 2, else give data2, data1, data0
  task automatic t_iso_pid();
    for (int m = 1; m <= 3; m++)
    begin
      inEpEnable[4] <= 1'b0;
      acc(1'b1, IN_TSIZE_BASE + 12'h010, {1'b0, 2'(m), 29'h0048_01F4}, "");
      inEpEnable[4] <= 1'b1;
      i_usb_core_model.frame();
      for (int j = m; j >= 0; j--)
      begin
        chk({30'h0, isoTxPid[4]}, {30'h0, j == 3 ? PID_DATA2 :
          (j == 2 ? PID_DATA1 : PID_DATA0)}, "iso pid");
        i_usb_core_model.send(1, 3'h4, 11'h004, 2'h0, 1'b0, 0);
      end
    end
  endtask

  // ce low freezes all state: a frame and a fill must leave no trace
  task automatic t_ce_hold();
    ce <= 1'b0;
    i_usb_core_model.frame();
    i_usb_core_model.send(0, 3'h2, 11'h040, 2'h0, 1'b0, 0);
    ce <= 1'b1;
    @(posedge mclk);
    chk({30'h0, isoTxPid[4]}, {30'h0, PID_DATA0}, "frozen pid");
    acc(1'b0, TX_FREE_BASE + 12'h008, 32'h0000_01F7, "ce free");
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // reset for 12 cycles, then the scenarios in turn
  initial
  begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_reset_ro();
    t_in_flow();
    t_out_flow();
    t_iso_pid();
    t_ce_hold();
    wrap_up();
  end

  // the run needs about two hundred cycles; 25000 means a hang
  initial
  begin
    #100000;
    miscompares++;
    wrap_up();
  end
endmodule
